//--- hw/dsru_pkg.sv
package dsru_pkg;

  // operation codes presented by the pipeline
  typedef enum logic [2:0] {
    DSRU_OP_NONE,
    DSRU_OP_REPLICATE_BYTE_VARIABLE,
    DSRU_OP_ACCUMULATOR_SHIFT_IMMEDIATE,
    DSRU_OP_ACCUMULATOR_SHIFT_VARIABLE,
    DSRU_OP_HALFWORD_PAIR_SHIFT_LEFT,
    DSRU_OP_HALFWORD_PAIR_SHIFT_LEFT_VARIABLE
  } dsru_op_e;

  localparam int unsigned DSRU_WORD_W       = 32;
  localparam int unsigned DSRU_ACC_W        = 64;
  localparam int unsigned DSRU_LANE_W       = 16;
  localparam int unsigned DSRU_BYTE_W       = 8;
  localparam int unsigned DSRU_ACC_AMT_W    = 6;
  localparam int unsigned DSRU_HW_AMT_W     = 4;
  localparam int unsigned DSRU_PAIR_SEL_W   = 2;
  localparam int unsigned DSRU_PAIR_COUNT   = 4;
  localparam int unsigned DSRU_OVF_LANE_BIT = 22;
  localparam logic [15:0] DSRU_LANE_MAX_POS = 16'h7FFF;
  localparam logic [15:0] DSRU_LANE_MAX_NEG = 16'h8000;
  localparam logic [63:0] DSRU_ACC_RESET    = 64'h0000_0000_0000_0000;

endpackage : dsru_pkg

//--- hw/dsru_acc_mem.sv
`timescale 1ns/100ps
`default_nettype none

// accumulator pairs; registered read, one write port
module dsru_acc_mem
  import dsru_pkg::*;
#(
  parameter int unsigned PAIRS = DSRU_PAIR_COUNT
) (
  // clock and reset
  input  wire  logic                       ref_clk_i,
  input  wire  logic                       rst_i,
  // read port
  input  wire  logic [DSRU_PAIR_SEL_W-1:0] rd_sel_i,
  output logic       [DSRU_ACC_W-1:0]      rd_data_o,
  // write port
  input  wire  logic                       wr_en_i,
  input  wire  logic [DSRU_PAIR_SEL_W-1:0] wr_sel_i,
  input  wire  logic [DSRU_ACC_W-1:0]      wr_data_i
);

  logic [DSRU_ACC_W-1:0] acc_q [PAIRS];

  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : g_pair
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          acc_q[g] <= DSRU_ACC_RESET;
        end else if (wr_en_i && (wr_sel_i == g[DSRU_PAIR_SEL_W-1:0])) begin
          acc_q[g] <= wr_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_data_o <= DSRU_ACC_RESET;
    end else begin
      rd_data_o <= acc_q[rd_sel_i];
    end
  end

endmodule : dsru_acc_mem

`default_nettype wire

//--- hw/dsru_unit.sv
// Contract
// - replicate-byte copies source low byte into all four destination byte lanes
// - accumulator shift treats upper:bottom words as one 64-bit value
// - shift amount signed 6-bit; negative shifts left, otherwise right
// - accumulator shifts are logical, zero filled, no sign extension
// - pair selector picks one of four pairs; pair 0 is base pair
// - shifted result goes back to the same pair only
// - variable accumulator shift uses low 6 bits of shift operand
// - halfword shift moves each 16-bit lane independently, zero fill
// - immediate halfword shift count is a 4-bit field, 0 to 15
// - saturating lane overflow gives 0x7FFF positive or 0x8000 negative
// - saturation decided and applied per lane independently
// - any lane overflow in halfword shift sets overflow flag bit 22
// - variable halfword shift equals immediate form with register count
// - variable halfword count is low 4 bits of shift operand
// - no data-dependent exception is ever raised
`timescale 1ns/100ps
`default_nettype none

module dsru_unit
  import dsru_pkg::*;
(
  // clock and reset
  input  wire  logic                       ref_clk_i,
  input  wire  logic                       rst_i,
  // decoded request
  input  wire  logic                       valid_i,
  input  wire  dsru_op_e                   op_i,
  input  wire  logic                       saturate_i,
  input  wire  logic [DSRU_ACC_AMT_W-1:0]  shift_amount_i,
  input  wire  logic [DSRU_PAIR_SEL_W-1:0] pair_selector_i,
  input  wire  logic [DSRU_WORD_W-1:0]     source_operand_i,
  input  wire  logic [DSRU_WORD_W-1:0]     shift_operand_i,
  // accumulator load from the pipeline
  input  wire  logic                       acc_load_i,
  input  wire  logic [DSRU_ACC_W-1:0]      acc_load_data_i,
  // register file result
  output logic                             ready_o,
  output logic                             gpr_wr_o,
  output logic       [DSRU_WORD_W-1:0]     gpr_data_o,
  // accumulator visibility and flag
  output logic       [DSRU_ACC_W-1:0]      acc_rd_data_o,
  output logic                             ovf_set_o,
  output logic       [DSRU_WORD_W-1:0]     ovf_flag_mask_o,
  output logic                             exception_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {DSRU_IDLE, DSRU_ACC_READ, DSRU_ACC_WRITE} dsru_state_e;

  dsru_state_e                  state_q;
  dsru_state_e                  state_d;
  logic [DSRU_PAIR_SEL_W-1:0]   pair_q;
  logic [DSRU_ACC_AMT_W-1:0]    acc_amt_q;
  logic [DSRU_ACC_W-1:0]        acc_rd;
  logic [DSRU_ACC_W-1:0]        acc_shifted;
  logic                         acc_wr;
  logic [DSRU_WORD_W-1:0]       gpr_data_q;
  logic [DSRU_WORD_W-1:0]       gpr_data_d;
  logic                         gpr_wr_q;
  logic                         ovf_q;

  ////////////////////////////////////////////////////////////////////////////
  // halfword lane shift with overflow detection
  function automatic logic [16:0] lane_shift(input logic [15:0] v, input logic [3:0] n,
                                             input logic sat);
    logic [31:0] wide;
    logic [15:0] res;
    logic        ovf;
    wide = {{16{v[15]}}, v} << n;
    res  = wide[15:0];
    // signed overflow: bits shifted through the sign differ from it
    ovf  = (n != 4'h0) && (wide[31:15] != {17{v[15]}});
    if (sat && ovf) begin
      res = v[15] ? DSRU_LANE_MAX_NEG : DSRU_LANE_MAX_POS;
    end
    return {ovf, res};
  endfunction : lane_shift

  wire       is_hw_imm   = (op_i == DSRU_OP_HALFWORD_PAIR_SHIFT_LEFT);
  wire       is_hw_var   = (op_i == DSRU_OP_HALFWORD_PAIR_SHIFT_LEFT_VARIABLE);
  wire       is_hw       = valid_i && (is_hw_imm || is_hw_var);
  wire       is_rep      = valid_i && (op_i == DSRU_OP_REPLICATE_BYTE_VARIABLE);
  wire       is_acc_imm  = (op_i == DSRU_OP_ACCUMULATOR_SHIFT_IMMEDIATE);
  wire       is_acc_var  = (op_i == DSRU_OP_ACCUMULATOR_SHIFT_VARIABLE);
  wire       is_acc      = valid_i && (is_acc_imm || is_acc_var);
  // immediate count is the 4-bit field; variable takes low 4 operand bits
  wire [3:0] hw_amt      = is_hw_var ? shift_operand_i[DSRU_HW_AMT_W-1:0]
                                     : shift_amount_i[DSRU_HW_AMT_W-1:0];
  // each lane decides its own overflow and saturation
  wire [16:0] lane_lo    = lane_shift(source_operand_i[15:0], hw_amt, saturate_i);
  wire [16:0] lane_hi    = lane_shift(source_operand_i[31:16], hw_amt, saturate_i);
  wire       lane_ovf    = lane_lo[16] | lane_hi[16];
  wire [DSRU_ACC_AMT_W-1:0] acc_amt = is_acc_var ? shift_operand_i[DSRU_ACC_AMT_W-1:0]
                                                 : shift_amount_i;

  always_comb begin
    gpr_data_d = gpr_data_q;
    // requests while busy are refused and must not disturb the held result
    if (ready_o && is_rep) begin
      gpr_data_d = {4{source_operand_i[DSRU_BYTE_W-1:0]}};
    end else if (ready_o && is_hw) begin
      gpr_data_d = {lane_hi[15:0], lane_lo[15:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator: read pair, shift, write back
  wire       acc_left   = acc_amt_q[DSRU_ACC_AMT_W-1];
  wire [5:0] left_mag   = 6'(-acc_amt_q);
  assign acc_shifted = acc_left ? (acc_rd << left_mag)
                                : (acc_rd >> acc_amt_q[4:0]);
  assign acc_wr      = (state_q == DSRU_ACC_WRITE);
  assign ready_o     = (state_q == DSRU_IDLE);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DSRU_IDLE:      if (is_acc) state_d = DSRU_ACC_READ;
      DSRU_ACC_READ:  state_d = DSRU_ACC_WRITE;
      DSRU_ACC_WRITE: state_d = DSRU_IDLE;
    endcase
  end

  // load shares the write port; taken only when idle, so never meets a write-back
  wire                       acc_load_now = ready_o && acc_load_i && !is_acc;
  wire                       mem_wr_en    = acc_wr || acc_load_now;
  wire [DSRU_PAIR_SEL_W-1:0] mem_wr_sel   = acc_wr ? pair_q : pair_selector_i;
  wire [DSRU_ACC_W-1:0]      mem_wr_data  = acc_wr ? acc_shifted : acc_load_data_i;

  // upper word sits in bits 63..32 of each stored pair
  dsru_acc_mem #(.PAIRS(DSRU_PAIR_COUNT)) u_acc (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .rd_sel_i  (pair_q),
    .rd_data_o (acc_rd),
    .wr_en_i   (mem_wr_en),
    .wr_sel_i  (mem_wr_sel),
    .wr_data_i (mem_wr_data)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q    <= DSRU_IDLE;
      pair_q     <= '0;
      acc_amt_q  <= '0;
      gpr_data_q <= '0;
      gpr_wr_q   <= 1'b0;
      ovf_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      gpr_data_q <= gpr_data_d;
      gpr_wr_q   <= ready_o && (is_rep || is_hw);
      ovf_q      <= ready_o && is_hw && lane_ovf;
      if (ready_o && is_acc) begin
        pair_q    <= pair_selector_i;
        acc_amt_q <= acc_amt;
      end else if (acc_load_now) begin
        pair_q    <= pair_selector_i;
      end
    end
  end

  assign gpr_wr_o        = gpr_wr_q;
  assign gpr_data_o      = gpr_data_q;
  assign acc_rd_data_o   = acc_rd;
  assign ovf_set_o       = ovf_q;
  assign ovf_flag_mask_o = ovf_q ? (32'h0000_0001 << DSRU_OVF_LANE_BIT) : 32'h0000_0000;
  assign exception_o     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  a_no_exception: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !exception_o) else $error("exception raised");
  a_rep_bytes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_rep) |=> gpr_data_o == {4{$past(source_operand_i[7:0])}})
    else $error("byte replicate wrong");
  a_hw_var_lanes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && valid_i && is_hw_var && !saturate_i) |=>
      gpr_data_o[15:0] == 16'($past(source_operand_i[15:0]) << $past(shift_operand_i[3:0])))
    else $error("variable halfword shift wrong");
  a_ovf_zero_cnt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_hw && hw_amt == 4'h0) |=> !ovf_set_o)
    else $error("overflow on zero count");
  a_sat_pos_lane: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_hw && saturate_i && lane_lo[16] && !source_operand_i[15]) |=>
      gpr_data_o[15:0] == 16'h7FFF) else $error("positive saturation wrong");
  a_ovf_bit22: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ovf_set_o |-> ovf_flag_mask_o == 32'h0040_0000) else $error("flag bit wrong");
  a_acc_two_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_acc) |=> !acc_wr ##1 acc_wr ##1 ready_o)
    else $error("accumulator sequence wrong");
  a_acc_right: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (acc_wr && !acc_amt_q[5] && acc_amt_q != 6'h00) |-> !acc_shifted[63])
    else $error("right shift not zero filled");
  a_acc_left_fill: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (acc_wr && acc_amt_q[5]) |-> !acc_shifted[0])
    else $error("left shift not zero filled");
  a_acc_imm_amt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && valid_i && is_acc_imm) |=> acc_amt_q == $past(shift_amount_i))
    else $error("immediate accumulator amount wrong");
  a_acc_var_amt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && valid_i && is_acc_var) |=> acc_amt_q == $past(shift_operand_i[5:0]))
    else $error("variable accumulator amount wrong");
  a_acc_pair_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_acc) |=> pair_q == $past(pair_selector_i) ##1 $stable(pair_q))
    else $error("accumulator pair changed");
  a_load_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    acc_load_now |=> pair_q == $past(pair_selector_i))
    else $error("loaded pair not selected");
  a_gpr_refused: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ready_o |=> !gpr_wr_o)
    else $error("register written while busy");
  a_sat_neg_lane: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_hw && saturate_i && lane_lo[16] && source_operand_i[15]) |=>
      gpr_data_o[15:0] == 16'h8000) else $error("negative saturation wrong");
  a_hw_imm_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && valid_i && is_hw_imm && !saturate_i) |=>
      gpr_data_o[31:16] == 16'($past(source_operand_i[31:16]) << $past(shift_amount_i[3:0])))
    else $error("immediate halfword shift wrong");
  a_lane_indep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_o && is_hw && saturate_i && lane_lo[16] && !lane_hi[16]) |=>
      gpr_data_o[31:16] == 16'($past(source_operand_i[31:16]) << $past(hw_amt)))
    else $error("lane saturation leaked");

endmodule : dsru_unit

`default_nettype wire

//--- bench/dsru_rf_model.sv
`timescale 1ns/100ps
`default_nettype none

// register file and control word as seen by the pipeline
module dsru_rf_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // results from the unit
  input  wire logic        gpr_wr_i,
  input  wire logic [31:0] gpr_data_i,
  input  wire logic        ovf_set_i,
  input  wire logic [31:0] ovf_flag_mask_i,
  // visible state
  output logic      [31:0] rf_word_o,
  output logic      [31:0] ctrl_word_o,
  output logic      [7:0]  wr_count_o
);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rf_word_o   <= 32'h0000_0000;
      ctrl_word_o <= 32'h0000_0000;
      wr_count_o  <= 8'h00;
    end else begin
      if (gpr_wr_i) begin
        rf_word_o  <= gpr_data_i;
        wr_count_o <= wr_count_o + 8'h01;
      end
      // sticky: only reset clears the flag
      if (ovf_set_i) ctrl_word_o <= ctrl_word_o | ovf_flag_mask_i;
    end
  end
endmodule : dsru_rf_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb
  import dsru_pkg::*;
();
  logic ref_clk, rst, valid, sat, ready, gwr, ovf, exc, ld;
  dsru_op_e op;
  logic [5:0]  amt;
  logic [1:0]  pair;
  logic [31:0] src, sop, gdata, mask, rf_word, ctrl;
  logic [63:0] acc, ld_data;
  logic [7:0]  wr_cnt;
  int mismatches = 0;
  int num_checks = 0;

  dsru_unit i_dut (.ref_clk_i(ref_clk), .rst_i(rst), .valid_i(valid), .op_i(op),
    .saturate_i(sat), .shift_amount_i(amt), .pair_selector_i(pair),
    .source_operand_i(src), .shift_operand_i(sop), .ready_o(ready), .gpr_wr_o(gwr),
    .acc_load_i(ld), .acc_load_data_i(ld_data),
    .gpr_data_o(gdata), .acc_rd_data_o(acc), .ovf_set_o(ovf),
    .ovf_flag_mask_o(mask), .exception_o(exc));
  dsru_rf_model i_rf (.ref_clk_i(ref_clk), .rst_i(rst), .gpr_wr_i(gwr),
    .gpr_data_i(gdata), .ovf_set_i(ovf), .ovf_flag_mask_i(mask),
    .rf_word_o(rf_word), .ctrl_word_o(ctrl), .wr_count_o(wr_cnt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_for(input logic want_ready);
    int n;
    for (n = 0; n < 8 && (want_ready ? ready : gwr) !== 1'b1; n++) @(negedge ref_clk);
    if ((want_ready ? ready : gwr) !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask : wait_for

  // operands always well formed for the op
  task automatic issue(input dsru_op_e o, input logic s, input logic [5:0] a,
                       input logic [1:0] p, input logic [31:0] x, input logic [31:0] y);
    @(negedge ref_clk);
    wait_for(1'b1);
    valid = 1'b1; op = o; sat = s; amt = a; pair = p; src = x; sop = y;
    @(negedge ref_clk);
    valid = 1'b0;
    chk(exc, 0);
  endtask : issue

  // per-lane reference, overflow in bit 32
  function automatic logic [32:0] hw_exp(input logic [31:0] x, input logic [3:0] c,
                                         input logic s);
    logic [31:0] w;
    logic [32:0] r;
    r = '0;
    for (int l = 0; l < 2; l++) begin
      w = {{16{x[16*l+15]}}, x[16*l+:16]} << c;
      if (c != 0 && w != {{16{w[15]}}, w[15:0]}) begin
        r[32] = 1'b1;
        if (s) w[15:0] = x[16*l+15] ? 16'h8000 : 16'h7FFF;
      end
      r[16*l+:16] = w[15:0];
    end
    return r;
  endfunction : hw_exp

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_replicate();
    logic [31:0] xs [2] = '{32'hA1B2_C3D4, 32'h0000_007F};
    for (int i = 0; i < 2; i++) begin
      issue(DSRU_OP_REPLICATE_BYTE_VARIABLE, 1'b0, 6'h00, 2'h0, xs[i], 32'hFFFF_FFFF);
      wait_for(1'b0);
      chk(gdata, {4{xs[i][7:0]}});
    end
    $display("replicate done");
  endtask : t_replicate

  task automatic t_halfword();
    logic [31:0] hs [5] = '{32'h0001_4000, 32'h0001_4000, 32'hC000_8000,
                            32'hFFFF_1234, 32'h0001_0001};
    logic [3:0]  hc [5] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'hF};
    logic        hz [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [32:0] e;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 5; i++) begin
        e = hw_exp(hs[i], hc[i], hz[i]);
        if (f == 0) issue(DSRU_OP_HALFWORD_PAIR_SHIFT_LEFT, hz[i], {2'b10, hc[i]}, 2'h0,
                          hs[i], {28'hFFFF_FFF, ~hc[i]});
        else issue(DSRU_OP_HALFWORD_PAIR_SHIFT_LEFT_VARIABLE, hz[i], {2'b01, ~hc[i]},
                   2'h0, hs[i], {28'hABCD_EF1, hc[i]});
        wait_for(1'b0);
        chk(gdata, e[31:0]);
        chk({ovf, mask}, {e[32], e[32] ? 32'h0040_0000 : 32'h0});
      end
    end
    $display("halfword done");
  endtask : t_halfword

  // signed amount: negative moves left by its magnitude, zero fill both ways
  function automatic logic [63:0] acc_exp(input logic [63:0] v, input logic [5:0] a);
    int s;
    s = $signed(a);
    return (s < 0) ? v << (-s) : v >> s;
  endfunction : acc_exp

  task automatic acc_load(input logic [1:0] p, input logic [63:0] d);
    @(negedge ref_clk);
    wait_for(1'b1);
    ld = 1'b1; pair = p; ld_data = d;
    @(negedge ref_clk);
    ld = 1'b0;
  endtask : acc_load

  // the unused amount source carries a decoy value
  task automatic acc_shift(input logic f, input logic [1:0] p, input logic [5:0] a,
                           input logic [63:0] e);
    issue(f ? DSRU_OP_ACCUMULATOR_SHIFT_VARIABLE : DSRU_OP_ACCUMULATOR_SHIFT_IMMEDIATE,
          1'b0, f ? ~a : a, p, 32'hFFFF_FFFF, {26'h3FF_FFFF, f ? a : ~a});
    chk({ready, gwr}, 2'b00);
    @(negedge ref_clk);
    chk({ready, gwr}, 2'b00);
    wait_for(1'b1);
    @(negedge ref_clk);
    chk(acc, e);
  endtask : acc_shift

  task automatic t_acc();
    logic [63:0] v [4] = '{64'h8000_0001_0000_0003, 64'hF0F0_1234_5678_0F0F,
                           64'h0000_0000_FFFF_FFFF, 64'hC000_0000_0000_0001};
    logic [5:0]  ia [4] = '{6'h20, 6'h01, 6'h3F, 6'h1F};
    logic [5:0]  va [4] = '{6'h00, 6'h21, 6'h1C, 6'h3E};
    logic [63:0] e;
    for (int p = 0; p < 4; p++) acc_load(p[1:0], v[p]);
    for (int p = 0; p < 4; p++) begin
      e = acc_exp(v[p], ia[p]);
      acc_shift(1'b0, p[1:0], ia[p], e);
      e = acc_exp(e, va[p]);
      acc_shift(1'b1, p[1:0], va[p], e);
      v[p] = e;
    end
    // zero shift re-reads every pair: no shift may have touched another pair
    for (int p = 0; p < 4; p++) acc_shift(1'b0, p[1:0], 6'h00, v[p]);
    issue(DSRU_OP_NONE, 1'b0, 6'h00, 2'h0, 32'h1234_5678, 32'h0);
    $display("accumulator done");
  endtask : t_acc

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1; valid = 1'b0; op = DSRU_OP_NONE; sat = 1'b0; amt = 6'h00;
    pair = 2'h0; src = 32'h0; sop = 32'h0;
    ld = 1'b0; ld_data = 64'h0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    t_replicate();
    t_halfword();
    t_acc();
    repeat (3) @(negedge ref_clk);
    chk({wr_cnt, rf_word}, {8'h0C, 32'h8000_8000});
    chk(ctrl, 32'h0040_0000);
    close_out();
  end
endmodule : tb
`default_nettype wire
